/* hw/osc_led_pkg.sv */
/*
 * Shared constants, register map and carrier types of the oscillator
 * and LED sink driver control block.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package osc_led_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_MHZ = 25;
   localparam int SETTLE_TIME_US = 100;
   // least time, exact at an integer clock rate in MHz
   localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
   localparam int SLOW_OSC_HZ = 10_000;
   // half period of the slow clock in system cycles
   localparam int SLOW_HALF_CYCLES = (CLK_MHZ * 1_000_000) /
                                     (2 * SLOW_OSC_HZ);
   localparam int SLOW_CNT_W = $clog2(SLOW_HALF_CYCLES);
   // fast clock half period in system cycles for the divide-by-one code
   localparam int FAST_BASE_HALF = 1;

   // settle timer indices
   localparam int SETTLE_FAST = 0;
   localparam int SETTLE_SLOW = 1;
   localparam int SETTLE_REF = 2;
   localparam int SETTLE_N = 3;

   // ****************************************************************
   // drive levels
   // ****************************************************************
   localparam int COLOUR_CH_N = 3;
   localparam int CH_LEVEL_W = 7;
   localparam int IR_LEVEL_W = 8;
   localparam int COLOUR_STEP_MA = 4;
   localparam int IR_STEP_MA = 50;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam int AXI_ADDR_W = 8;
   localparam logic [7:0] OFF_FAST_CTRL = 8'h00;
   localparam logic [7:0] OFF_SLOW_CTRL = 8'h04;
   localparam logic [7:0] OFF_DRIVER_CTRL = 8'h08;
   localparam logic [7:0] OFF_COLOUR_LEVEL = 8'h0C;
   localparam logic [7:0] OFF_IR_LEVEL = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_COLOUR_MA = 8'h18;
   localparam logic [7:0] OFF_IR_MA = 8'h1C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // carrier types
   // ****************************************************************
   typedef enum logic [1:0] {
      DIV_BY_1 = 2'b00,
      DIV_BY_2 = 2'b01,
      DIV_BY_4 = 2'b10,
      DIV_BY_8 = 2'b11
   } divide_code_t;

   typedef struct packed {
      divide_code_t divide;
      logic routing;
      logic output_enable;
      logic power_up;
   } fast_osc_t;

   typedef struct packed {
      logic routing;
      logic output_enable;
      logic power_up;
   } slow_osc_t;

   typedef struct packed {
      logic half_mode;
      logic ir_en;
      logic colour_en;
      logic ref_en;
   } driver_ctrl_t;

   typedef struct packed {
      logic ir_sink;
      logic [2:0] colour_sink;
      logic spare;
      logic ref_ready;
      logic slow_ready;
      logic fast_ready;
   } status_t;

   localparam fast_osc_t FAST_RESET = '0;
   localparam slow_osc_t SLOW_RESET = '0;
   localparam driver_ctrl_t DRIVER_RESET = '0;

endpackage : osc_led_pkg

/* hw/settle_timer.sv */
/*
 * Settling timer: raises ready after start has been high for COUNT
 * consecutive cycles, drops it as soon as start falls.
 * Assumes start is synchronous to clk_in.
 */
`timescale 1ns/1ps
module settle_timer
   import osc_led_pkg::*;
#(
   parameter int COUNT = SETTLE_CYCLES
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic start_in,
   output logic ready_out
);

   localparam int W = $clog2(COUNT + 1);

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   wire at_end = (count == W'(COUNT));

   // count up while start holds, saturating at the settle time
   assign next_count = !start_in ? '0 : (at_end ? count : count + 1'b1);

   // ****************************************************************
   // timer state
   // ****************************************************************
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         count <= '0;
         ready_out <= 1'b0;
      end else begin
         count <= next_count;
         ready_out <= (next_count == W'(COUNT));
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);

   ready_late_a: assert property ($rose(ready_out) |-> at_end)
      else $error("settle ready rose before the full count");
   ready_drop_a: assert property (!start_in |=> !ready_out)
      else $error("settle ready held after start fell");

endmodule : settle_timer

/* hw/osc_led_ctrl.sv */
/*
 * Oscillator and LED sink driver control with an AXI4-Lite register file.
 * Assumes a 25 MHz clock, synchronous PWM inputs and an outside pad that
 * combines each sink with its shared open-drain pad from the enables.
 */
`timescale 1ns/1ps
module osc_led_ctrl
   import osc_led_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic channel0_pwm_in,
   input wire logic channel1_pwm_in,
   input wire logic channel2_pwm_in,
   input wire logic infrared_pwm_in,
   output logic fast_osc_clock_out,
   output logic fast_osc_on_fabric_out,
   output logic slow_osc_clock_out,
   output logic slow_osc_on_fabric_out,
   output logic [2:0] led_sink_out,
   output logic [2:0] led_sink_oe_n_out,
   output logic [2:0] led_sink_owned_out,
   output logic infrared_sink_out,
   output logic infrared_sink_oe_n_out,
   output logic infrared_sink_owned_out
);

   // ****************************************************************
   // register state
   // ****************************************************************
   fast_osc_t fast_ctrl;
   slow_osc_t slow_ctrl;
   driver_ctrl_t drv_ctrl;
   logic [COLOUR_CH_N-1:0][CH_LEVEL_W-1:0] colour_level;
   logic [IR_LEVEL_W-1:0] infrared_level_code;
   logic [AXI_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [SETTLE_N-1:0] settle_ready;
   logic [3:0] fast_cnt;
   logic [SLOW_CNT_W-1:0] slow_cnt;

   // byte-lane merge of a write into the current register word
   function automatic logic [31:0] merge_word(input logic [31:0] cur,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] mask;
      mask = '0;
      for (int b = 0; b < 4; b++) begin
         mask[b*8 +: 8] = {8{strb[b]}};
      end
      return (cur & ~mask) | (data & mask);
   endfunction : merge_word

   // number of set bits of a level code
   function automatic int count_ones(input logic [7:0] v);
      int n;
      n = 0;
      for (int b = 0; b < 8; b++) begin
         n = n + int'(v[b]);
      end
      return n;
   endfunction : count_ones

   // ****************************************************************
   // settle timers: fast oscillator, slow oscillator, reference current
   // ****************************************************************
   wire [SETTLE_N-1:0] settle_start = {drv_ctrl.ref_en,
      slow_ctrl.power_up, fast_ctrl.power_up};

   for (genvar t = 0; t < SETTLE_N; t++) begin : g_settle
      settle_timer #(.COUNT(SETTLE_CYCLES)) u_settle (
         .clk_in(clk_in),
         .reset_in(reset_in),
         .start_in(settle_start[t]),
         .ready_out(settle_ready[t])
      );
   end

   // ****************************************************************
   // drive levels and sink decisions
   // ****************************************************************
   wire ref_gate = drv_ctrl.ref_en & settle_ready[SETTLE_REF];
   wire [2:0] pwm_vec = {channel2_pwm_in, channel1_pwm_in,
      channel0_pwm_in};
   wire [2:0] next_sink;
   wire [2:0] next_owned;
   wire [2:0][7:0] colour_ma;

   // one slice per colour channel
   for (genvar ch = 0; ch < COLOUR_CH_N; ch++) begin : g_chan
      wire code_nz = |colour_level[ch];
      assign next_owned[ch] = code_nz;
      assign next_sink[ch] = ref_gate & drv_ctrl.colour_en
         & pwm_vec[ch] & code_nz;
      assign colour_ma[ch] = 8'((count_ones({1'b0, colour_level[ch]}) *
         COLOUR_STEP_MA) >> drv_ctrl.half_mode);
   end

   wire ir_code_nz = |infrared_level_code;
   wire next_ir_sink = ref_gate & drv_ctrl.ir_en & infrared_pwm_in &
      ir_code_nz;
   wire [8:0] ir_ma = 9'((count_ones(infrared_level_code) * IR_STEP_MA)
      >> drv_ctrl.half_mode);

   // ****************************************************************
   // oscillators
   // ****************************************************************
   // output runs only when powered, settled and enabled
   wire fast_run = fast_ctrl.power_up & settle_ready[SETTLE_FAST] &
      fast_ctrl.output_enable;
   wire slow_run = slow_ctrl.power_up & settle_ready[SETTLE_SLOW] &
      slow_ctrl.output_enable;
   wire [3:0] fast_half = 4'(FAST_BASE_HALF) << fast_ctrl.divide;
   wire fast_wrap = (fast_cnt == fast_half - 4'h1);
   wire slow_wrap = (slow_cnt == SLOW_CNT_W'(SLOW_HALF_CYCLES - 1));

   // fast clock toggle divider
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fast_cnt <= 4'h0;
         fast_osc_clock_out <= 1'b0;
      end else if (!fast_run || fast_wrap) begin
         fast_cnt <= 4'h0;
         fast_osc_clock_out <= fast_run & ~fast_osc_clock_out;
      end else begin
         fast_cnt <= fast_cnt + 4'h1;
      end
   end

   // slow clock toggle divider, fixed rate
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         slow_cnt <= '0;
         slow_osc_clock_out <= 1'b0;
      end else if (!slow_run || slow_wrap) begin
         slow_cnt <= '0;
         slow_osc_clock_out <= slow_run & ~slow_osc_clock_out;
      end else begin
         slow_cnt <= slow_cnt + 1'b1;
      end
   end

   // routing selects and sink pin state
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fast_osc_on_fabric_out <= 1'b0;
         slow_osc_on_fabric_out <= 1'b0;
         led_sink_out <= 3'h0;
         led_sink_oe_n_out <= 3'h7;
         led_sink_owned_out <= 3'h0;
         infrared_sink_out <= 1'b0;
         infrared_sink_oe_n_out <= 1'b1;
         infrared_sink_owned_out <= 1'b0;
      end else begin
         fast_osc_on_fabric_out <= fast_ctrl.routing;
         slow_osc_on_fabric_out <= slow_ctrl.routing;
         led_sink_out <= 3'h0;
         led_sink_oe_n_out <= ~next_sink;
         led_sink_owned_out <= next_owned;
         infrared_sink_out <= 1'b0;
         infrared_sink_oe_n_out <= ~next_ir_sink;
         infrared_sink_owned_out <= ir_code_nz;
      end
   end

   // ****************************************************************
   // register read words and decode
   // ****************************************************************
   status_t status;
   assign status = '{ir_sink: ~infrared_sink_oe_n_out,
      colour_sink: ~led_sink_oe_n_out, spare: 1'b0,
      ref_ready: settle_ready[SETTLE_REF],
      slow_ready: settle_ready[SETTLE_SLOW],
      fast_ready: settle_ready[SETTLE_FAST]};
   wire [31:0] fast_word = 32'(fast_ctrl);
   wire [31:0] slow_word = 32'(slow_ctrl);
   wire [31:0] drv_word = 32'(drv_ctrl);
   wire [31:0] colour_word = {9'h000, colour_level[2], 1'b0,
      colour_level[1], 1'b0, colour_level[0]};
   wire [31:0] ir_word = 32'(infrared_level_code);
   wire [31:0] status_word = 32'(status);
   wire [31:0] colour_ma_word = {8'h00, colour_ma[2], colour_ma[1],
      colour_ma[0]};
   wire [31:0] ir_ma_word = 32'(ir_ma);

   // write decode
   wire w_fast = (aw_addr == OFF_FAST_CTRL);
   wire w_slow = (aw_addr == OFF_SLOW_CTRL);
   wire w_drv = (aw_addr == OFF_DRIVER_CTRL);
   wire w_colour = (aw_addr == OFF_COLOUR_LEVEL);
   wire w_ir = (aw_addr == OFF_IR_LEVEL);
   wire w_ro = (aw_addr == OFF_STATUS) || (aw_addr == OFF_COLOUR_MA) ||
      (aw_addr == OFF_IR_MA);
   wire w_mapped = w_fast | w_slow | w_drv | w_colour | w_ir | w_ro;
   wire [31:0] w_cur = w_fast ? fast_word : w_slow ? slow_word :
      w_drv ? drv_word : w_colour ? colour_word : ir_word;
   wire [31:0] w_merged = merge_word(w_cur, w_data, w_strb);
   // both halves held and no response pending
   wire do_write = !s_axi_awready_out && !s_axi_wready_out &&
      !s_axi_bvalid_out;

   // read decode
   wire [7:0] ra = s_axi_araddr_in;
   wire r_mapped = (ra <= OFF_IR_MA) && (ra[1:0] == 2'b00);
   wire [31:0] r_word = (ra == OFF_FAST_CTRL) ? fast_word :
      (ra == OFF_SLOW_CTRL) ? slow_word :
      (ra == OFF_DRIVER_CTRL) ? drv_word :
      (ra == OFF_COLOUR_LEVEL) ? colour_word :
      (ra == OFF_IR_LEVEL) ? ir_word :
      (ra == OFF_STATUS) ? status_word :
      (ra == OFF_COLOUR_MA) ? colour_ma_word :
      (ra == OFF_IR_MA) ? ir_ma_word : 32'h0000_0000;
   wire ar_take = s_axi_arvalid_in && s_axi_arready_out;

   // ****************************************************************
   // AXI4-Lite write channels
   // ****************************************************************
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_addr <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= w_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

   // writable registers, all zero after reset
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fast_ctrl <= FAST_RESET;
         slow_ctrl <= SLOW_RESET;
         drv_ctrl <= DRIVER_RESET;
         colour_level <= '0;
         infrared_level_code <= '0;
      end else if (do_write) begin
         if (w_fast) fast_ctrl <= fast_osc_t'(w_merged[4:0]);
         if (w_slow) slow_ctrl <= slow_osc_t'(w_merged[2:0]);
         if (w_drv) drv_ctrl <= driver_ctrl_t'(w_merged[3:0]);
         if (w_colour) colour_level <= {w_merged[22:16], w_merged[14:8],
            w_merged[6:0]};
         if (w_ir) infrared_level_code <= w_merged[7:0];
      end
   end

   // ****************************************************************
   // AXI4-Lite read channels
   // ****************************************************************
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= r_word;
         s_axi_rresp_out <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   logic slow_prev;
   logic slow_seen;
   logic [11:0] slow_gap;
   wire slow_chg = (slow_prev != slow_osc_clock_out);

   // half-period length of the slow clock, seen from its output
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         slow_prev <= 1'b0;
         slow_seen <= 1'b0;
         slow_gap <= 12'h000;
      end else begin
         slow_prev <= slow_osc_clock_out;
         slow_seen <= slow_run & (slow_seen | slow_chg);
         slow_gap <= slow_chg ? 12'h001 :
            (&slow_gap ? slow_gap : slow_gap + 12'h001);
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);

   fast_gated_a: assert property (!settle_ready[SETTLE_FAST] |=> !fast_osc_clock_out)
      else $error("fast clock ran before settling");
   fast_div1_a: assert property (($rose(fast_osc_clock_out) && fast_ctrl.divide == DIV_BY_1) |=> (!fast_osc_clock_out || $changed(fast_ctrl.divide)))
      else $error("fast clock high longer than one cycle at divide 1");
   fast_div8_a: assert property (($rose(fast_osc_clock_out) && fast_ctrl.divide == DIV_BY_8) ##1 (fast_run && fast_ctrl.divide == DIV_BY_8) [*7] |-> fast_osc_clock_out ##1 !fast_osc_clock_out)
      else $error("fast clock half period wrong at divide 8");
   slow_period_a: assert property ((slow_chg && slow_seen && $past(slow_run)) |-> slow_gap == 12'(SLOW_HALF_CYCLES))
      else $error("slow clock half period wrong");
   off_default_a: assert property (!fast_ctrl.power_up |=> (!fast_osc_clock_out && !settle_ready[SETTLE_FAST]))
      else $error("fast clock active while powered down");
   routing_a: assert property (##1 (fast_osc_on_fabric_out == $past(fast_ctrl.routing)) && (slow_osc_on_fabric_out == $past(slow_ctrl.routing)))
      else $error("routing select does not follow its bit");
   release_zero_a: assert property (colour_level[1] == 7'h00 |=> (led_sink_oe_n_out[1] && !led_sink_owned_out[1]))
      else $error("colour pin not released at zero level");
   ref_gate_a: assert property (!ref_gate |=> (&led_sink_oe_n_out && infrared_sink_oe_n_out))
      else $error("sink active without settled reference");
   colour_en_a: assert property (!drv_ctrl.colour_en |=> &led_sink_oe_n_out)
      else $error("colour sink active while driver disabled");
   follow_pwm_a: assert property ((ref_gate && drv_ctrl.colour_en && colour_level[0] != 7'h00) |=> led_sink_oe_n_out[0] == !$past(channel0_pwm_in))
      else $error("colour sink does not follow its pwm input");
   colour_ma_a: assert property (colour_level[0] == 7'h3F |-> colour_ma[0] == (drv_ctrl.half_mode ? 8'h0C : 8'h18))
      else $error("colour current wrong for six set bits");
   ir_follow_a: assert property ((ref_gate && drv_ctrl.ir_en && ir_code_nz) |=> infrared_sink_oe_n_out == !$past(infrared_pwm_in))
      else $error("infrared sink does not follow its pwm input");
   ir_ma_a: assert property (infrared_level_code == 8'h03 |-> ir_ma == (drv_ctrl.half_mode ? 9'h032 : 9'h064))
      else $error("infrared current wrong for two set bits");
   ir_release_a: assert property (!ir_code_nz |=> (infrared_sink_oe_n_out && !infrared_sink_owned_out))
      else $error("infrared pin not released at zero level");

   fast_run_c: cover property (fast_ctrl.divide == DIV_BY_8 && $rose(fast_osc_clock_out));
   colour_sink_c: cover property ($fell(led_sink_oe_n_out[2]));
   ir_sink_c: cover property ($fell(infrared_sink_oe_n_out));
   write_c: cover property (s_axi_bvalid_out && s_axi_bready_in);

endmodule : osc_led_ctrl

/* testbench/pwm_source.sv */
/* fabric partner: drives the four sink pwm levels.
   assumes the bench supplies the wanted pattern and the clock. */
`timescale 1ns/1ps
module pwm_source (
   input wire logic clk_in,
   input wire logic [3:0] pattern_in,
   output logic [3:0] pwm_out
);
   // levels change just after a rising edge
   initial pwm_out = 4'h0;
   always @(posedge clk_in) begin
      pwm_out <= pattern_in;
   end
endmodule : pwm_source

/* testbench/tb_top.sv */
/* self-checking bench of osc_led_ctrl over its register bus.
   assumes pwm_source as the fabric partner and the package map. */
`timescale 1ns/1ps
module tb_top;
   import osc_led_pkg::*;
   logic clk_in = 0, reset_in = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic awr, wrd, bv, arr, rv, fclk, ffab, sclk, sfab, ir, ir_oe_n, ir_own;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [2:0] sink, oe_n, own;
   logic [3:0] pat = 0, pwm;
   logic [3:0] en [4] = '{4'h7, 4'h5, 4'h3, 4'h6};
   int fail_count = 0, check_count = 0, seed = 57126, p, c0, c1, c2, ci, k;
   always #20 clk_in = ~clk_in;
   pwm_source u_pwm_source (.clk_in(clk_in), .pattern_in(pat), .pwm_out(pwm));
   osc_led_ctrl u_osc_led_ctrl (.clk_in(clk_in), .reset_in(reset_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
      .channel0_pwm_in(pwm[0]), .channel1_pwm_in(pwm[1]),
      .channel2_pwm_in(pwm[2]), .infrared_pwm_in(pwm[3]),
      .fast_osc_clock_out(fclk), .fast_osc_on_fabric_out(ffab),
      .slow_osc_clock_out(sclk), .slow_osc_on_fabric_out(sfab),
      .led_sink_out(sink), .led_sink_oe_n_out(oe_n),
      .led_sink_owned_out(own), .infrared_sink_out(ir),
      .infrared_sink_oe_n_out(ir_oe_n), .infrared_sink_owned_out(ir_own));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] a, e);
      check_count++;
      if (a !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, a, e);
      end
   endtask : chk
   // bounded wait for a level sampled high at a rising edge
   task automatic hold(ref logic s);
      int i;
      for (i = 0; i < 99; i++) begin
         @(posedge clk_in);
         if (s === 1'b1) break;
      end
      if (i == 99) begin
         fail_count++;
         print_verdict();
      end
   endtask : hold
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      awaddr <= a; wdata <= v; awv <= 1; wv <= 1; br <= 1;
      hold(awr);
      awv <= 0;
      if (wrd !== 1'b1) hold(wrd);
      wv <= 0;
      hold(bv);
      r = bresp; br <= 0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge clk_in);
      araddr <= a; arv <= 1; rr <= 1;
      hold(arr);
      arv <= 0;
      hold(rv);
      d = rdata; r = rresp; rr <= 0;
   endtask : rreg
   // cycles between two toggles of a modelled oscillator
   task automatic period(ref logic c);
      logic v;
      @(posedge clk_in);
      v = c;
      for (p = 0; p < 5000 && c === v; p++) @(posedge clk_in);
      if (p == 5000) fail_count++;
      v = c;
      for (p = 1; p < 5000; p++) begin
         @(posedge clk_in);
         if (c !== v) break;
      end
   endtask : period
   function automatic int rnd(input int m);
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return (seed & 32'h7FFF_FFFF) % m;
   endfunction : rnd
   function automatic int ma(input int n, s, h);
      return n * s >> h;
   endfunction : ma
   // reset, register walk, levels, sinks, then both oscillators
   initial begin
      repeat (3) @(posedge clk_in);
      reset_in <= 0;
      chk({fclk, sclk, oe_n, ir_oe_n, own, ir_own}, 10'h0F0);
      for (k = 0; k < 9; k++) begin
         rreg(8'(4 * k));
         chk(d, 0);
         chk(r, k < 8 ? RESP_OKAY : RESP_SLVERR);
      end
      wreg(8'h20, 32'hFFFF_FFFF);
      chk(r, RESP_SLVERR);
      for (k = 0; k < 8; k++) begin
         c0 = rnd(7); c1 = rnd(7); c2 = rnd(7); ci = rnd(9);
         wreg(OFF_DRIVER_CTRL, k % 2 * 8);
         wreg(OFF_COLOUR_LEVEL,
            (1 << c2) - 1 << 16 | (1 << c1) - 1 << 8 | (1 << c0) - 1);
         wreg(OFF_IR_LEVEL, (1 << ci) - 1);
         rreg(OFF_COLOUR_MA);
         chk(d, ma(c2, 4, k % 2) << 16 | ma(c1, 4, k % 2) << 8
            | ma(c0, 4, k % 2));
         rreg(OFF_IR_MA);
         chk(d, ma(ci, 50, k % 2));
      end
      wreg(OFF_COLOUR_LEVEL, 32'h003F_0001);
      wreg(OFF_IR_LEVEL, 32'h0000_0003);
      pat <= 4'hF;
      wreg(OFF_DRIVER_CTRL, 32'h0000_0007);
      repeat (9) @(posedge clk_in);
      chk({oe_n, ir_oe_n}, 4'hF);
      repeat (SETTLE_CYCLES) @(posedge clk_in);
      for (k = 0; k < 20; k++) begin
         pat <= 4'(rnd(16));
         repeat (3) @(posedge clk_in);
         chk({sink, ir, oe_n, ir_oe_n},
            {4'h0, ~pat[2], 1'b1, ~pat[0], ~pat[3]});
         chk({own, ir_own}, 4'hB);
      end
      rreg(OFF_STATUS);
      chk(d, {pat[3], pat[2], 1'b0, pat[0], 4'h4});
      pat <= 4'hF;
      foreach (en[i]) begin
         wreg(OFF_DRIVER_CTRL, en[i]);
         repeat (3) @(posedge clk_in);
         chk({oe_n, ir_oe_n}, {en[i][1:0] == 3 ? 3'h2 : 3'h7,
            !(en[i][0] && en[i][2])});
      end
      wreg(OFF_FAST_CTRL, 1);
      repeat (SETTLE_CYCLES) @(posedge clk_in);
      for (k = 0; k < 4; k++) begin
         wreg(OFF_FAST_CTRL, k << 3 | k % 2 << 2 | 3);
         period(fclk);
         chk(p, 1 << k);
         chk(ffab, k % 2);
      end
      wreg(OFF_SLOW_CTRL, 7);
      repeat (99) @(posedge clk_in);
      chk(sclk, 0);
      period(sclk);
      chk(p, SLOW_HALF_CYCLES);
      chk(sfab, 1);
      print_verdict();
   end
endmodule : tb_top
